/* File: hw/pmr_bank.sv */
// pmr_bank: PHY management register bank reached by index through the
// MAC indirect access command and data path.
// assumes: access port and PHY status inputs are on clk_i.
// Behaviour
// - registers reached only by index, not mapped
// - decode indices 0-6,17,18,27,29,30,31
// - control bit 15 starts soft reset, self-clears
// - kept fields survive soft reset only
// - bit 14 loopback, resets to zero
// - bit 13 speed, ignored under autoneg
// - bit 12 autoneg enable, resets one, overrides
// - bit 11 power down; clears completion status
// - bit 9 restarts autoneg, self-clears
// - bit 8 duplex, ignored under autoneg
// - bit 7 collision test, resets zero
// - speed, duplex reset from autoneg result
// - status bit 5 shows autoneg complete
`timescale 1ns/1ps
`default_nettype none
module pmr_bank #(
  parameter logic [15:0] ID_HI = 16'h1234, // arbitrary value
  parameter logic [15:0] ID_LO = 16'h5678, // arbitrary value
  parameter logic [15:0] EXPAN_VAL = 16'h0000
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // indirect access command
  input wire logic acc_valid_i,
  input wire logic acc_write_i,
  input wire logic [4:0] acc_index_i,
  input wire logic [15:0] acc_wdata_i,
  // access answer
  output logic rsp_valid_o,
  output logic [15:0] rsp_rdata_o,
  // autoneg and line state
  input wire logic an_done_i,
  input wire logic an_speed100_i,
  input wire logic an_full_duplex_i,
  input wire logic link_up_i,
  input wire logic [15:0] partner_ability_i,
  input wire logic [15:0] irq_event_i,
  // phy control
  output logic soft_reset_o,
  output logic loopback_o,
  output logic speed100_o,
  output logic full_duplex_o,
  output logic an_enable_o,
  output logic an_restart_o,
  output logic power_down_o,
  output logic coll_test_o
);
  import pmr_pkg::*;

  localparam int SRC = SRST_CYC;
  localparam logic [4:0] SRST_LOAD = 5'(SRST_CYC);

  logic wr;
  logic rd;
  logic wr_ctrl;
  logic srst_req;
  logic soft_pulse_reg;
  logic [4:0] srst_cnt_reg;
  logic loop_reg;
  logic spd_reg;
  logic anen_reg;
  logic pdn_reg;
  logic anrs_reg;
  logic dup_reg;
  logic colt_reg;
  logic an_spd_reg;
  logic an_dup_reg;
  logic an_cmpl_reg;
  logic link_ll_reg;
  logic [15:0] irq_src_reg;
  logic rsp_valid_reg;
  logic [15:0] rdata_reg;
  logic [15:0] rdata_next;
  logic spd_out_reg;
  logic dup_out_reg;
  logic [15:0] ctrl_val;
  logic [15:0] stat_val;
  logic [15:0] adv_q;
  logic [15:0] mode_q;
  logic [15:0] spmode_q;
  logic [15:0] spind_q;
  logic [15:0] mask_q;
  logic [15:0] spctrl_q;
  logic [4:0] rsp_idx_reg;

  // ==========================================================
  // access decode
  assign wr = acc_valid_i & acc_write_i;
  assign rd = acc_valid_i & ~acc_write_i;
  assign wr_ctrl = wr && (acc_index_i == IDX_BCTRL);
  assign srst_req = wr_ctrl & acc_wdata_i[B_SRST];

  // ==========================================================
  // soft reset sequencer
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      srst_cnt_reg <= 5'h00;
      soft_pulse_reg <= 1'b0;
    end else begin
      soft_pulse_reg <= srst_req;
      if (srst_req) begin
        srst_cnt_reg <= SRST_LOAD;
      end else if (srst_cnt_reg != 5'h00) begin
        srst_cnt_reg <= srst_cnt_reg - 5'h01;
      end
    end
  end

  // ==========================================================
  // basic control fields
  always_ff @(posedge clk_i) begin
    if (sys_rst_i || soft_pulse_reg) begin
      loop_reg <= RST_LOOP;
      anen_reg <= RST_ANEN;
      pdn_reg <= RST_PDN;
      colt_reg <= RST_COLT;
      spd_reg <= sys_rst_i ? an_speed100_i : an_spd_reg;
      dup_reg <= sys_rst_i ? an_full_duplex_i : an_dup_reg;
    end else if (wr_ctrl && !acc_wdata_i[B_SRST]) begin
      loop_reg <= acc_wdata_i[B_LOOP];
      spd_reg <= acc_wdata_i[B_SPD];
      anen_reg <= acc_wdata_i[B_ANEN];
      pdn_reg <= acc_wdata_i[B_PDN];
      dup_reg <= acc_wdata_i[B_DUP];
      colt_reg <= acc_wdata_i[B_COLT];
    end else if (anen_reg && an_done_i) begin
      spd_reg <= an_speed100_i;
      dup_reg <= an_full_duplex_i;
    end
  end

  // ==========================================================
  // restart, self-clearing; also when a control write leaves power down
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      anrs_reg <= 1'b0;
    end else begin
      anrs_reg <= (wr_ctrl && !acc_wdata_i[B_SRST]
                   && acc_wdata_i[B_ANRS])
                  || (wr_ctrl && !acc_wdata_i[B_SRST]
                      && pdn_reg && !acc_wdata_i[B_PDN]);
    end
  end

  // ==========================================================
  // autoneg result and completion flag
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      an_spd_reg <= 1'b0;
      an_dup_reg <= 1'b0;
      an_cmpl_reg <= 1'b0;
    end else begin
      if (an_done_i) begin
        an_spd_reg <= an_speed100_i;
        an_dup_reg <= an_full_duplex_i;
      end
      if (an_done_i && anen_reg && !pdn_reg) begin
        an_cmpl_reg <= 1'b1;
      end else if (anrs_reg || pdn_reg || soft_pulse_reg) begin
        an_cmpl_reg <= 1'b0;
      end
    end
  end

  // ==========================================================
  // latching status and interrupt source
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      link_ll_reg <= 1'b0;
      irq_src_reg <= 16'h0000;
    end else begin
      if (!link_up_i) begin
        link_ll_reg <= 1'b0;
      end else if (rd && acc_index_i == IDX_BSTAT) begin
        link_ll_reg <= 1'b1;
      end else if (!link_ll_reg && acc_index_i != IDX_BSTAT) begin
        link_ll_reg <= link_ll_reg;
      end
      if (rd && acc_index_i == IDX_IRQ_SRC) begin
        irq_src_reg <= irq_event_i;
      end else begin
        irq_src_reg <= irq_src_reg | irq_event_i;
      end
    end
  end

  // ==========================================================
  // other indexed registers
  pmr_field_reg #(.RST_VAL(RST_ADV), .WR_MASK(WM_ADV),
    .KEEP_MASK(KEEP_NONE)) u_adv (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .soft_rst_i(soft_pulse_reg),
    .wr_en_i(wr && acc_index_i == IDX_ADV), .wdata_i(acc_wdata_i),
    .q_o(adv_q));
  pmr_field_reg #(.RST_VAL(RST_ZERO), .WR_MASK(WM_ALL),
    .KEEP_MASK(KEEP_NONE)) u_mode (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .soft_rst_i(soft_pulse_reg),
    .wr_en_i(wr && acc_index_i == IDX_MODE), .wdata_i(acc_wdata_i),
    .q_o(mode_q));
  pmr_field_reg #(.RST_VAL(RST_ZERO), .WR_MASK(WM_ALL),
    .KEEP_MASK(KEEP_SPMODE)) u_spmode (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .soft_rst_i(soft_pulse_reg),
    .wr_en_i(wr && acc_index_i == IDX_SPMODE), .wdata_i(acc_wdata_i),
    .q_o(spmode_q));
  pmr_field_reg #(.RST_VAL(RST_ZERO), .WR_MASK(WM_ALL),
    .KEEP_MASK(KEEP_NONE)) u_spind (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .soft_rst_i(soft_pulse_reg),
    .wr_en_i(wr && acc_index_i == IDX_SPIND), .wdata_i(acc_wdata_i),
    .q_o(spind_q));
  pmr_field_reg #(.RST_VAL(RST_ZERO), .WR_MASK(WM_ALL),
    .KEEP_MASK(KEEP_NONE)) u_mask (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .soft_rst_i(soft_pulse_reg),
    .wr_en_i(wr && acc_index_i == IDX_IRQ_MASK), .wdata_i(acc_wdata_i),
    .q_o(mask_q));
  pmr_field_reg #(.RST_VAL(RST_ZERO), .WR_MASK(WM_ALL),
    .KEEP_MASK(KEEP_NONE)) u_spctrl (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .soft_rst_i(soft_pulse_reg),
    .wr_en_i(wr && acc_index_i == IDX_SPCTRL), .wdata_i(acc_wdata_i),
    .q_o(spctrl_q));

  // ==========================================================
  // read view and index decode
  always_comb begin
    ctrl_val = 16'h0000;
    ctrl_val[B_SRST] = (srst_cnt_reg != 5'h00);
    ctrl_val[B_LOOP] = loop_reg;
    ctrl_val[B_SPD] = spd_reg;
    ctrl_val[B_ANEN] = anen_reg;
    ctrl_val[B_PDN] = pdn_reg;
    ctrl_val[B_ANRS] = anrs_reg;
    ctrl_val[B_DUP] = dup_reg;
    ctrl_val[B_COLT] = colt_reg;
    stat_val = BSTAT_FIXED;
    stat_val[S_ANC] = an_cmpl_reg;
    stat_val[S_LINK] = link_ll_reg;
  end

  always_comb begin
    if (acc_index_i == IDX_BCTRL) begin
      rdata_next = ctrl_val;
    end else if (acc_index_i == IDX_BSTAT) begin
      rdata_next = stat_val;
    end else if (acc_index_i == IDX_ID_HI) begin
      rdata_next = ID_HI;
    end else if (acc_index_i == IDX_ID_LO) begin
      rdata_next = ID_LO;
    end else if (acc_index_i == IDX_ADV) begin
      rdata_next = adv_q;
    end else if (acc_index_i == IDX_PARTNER) begin
      rdata_next = partner_ability_i;
    end else if (acc_index_i == IDX_EXPAN) begin
      rdata_next = EXPAN_VAL;
    end else if (acc_index_i == IDX_MODE) begin
      rdata_next = mode_q;
    end else if (acc_index_i == IDX_SPMODE) begin
      rdata_next = spmode_q;
    end else if (acc_index_i == IDX_SPIND) begin
      rdata_next = spind_q;
    end else if (acc_index_i == IDX_IRQ_SRC) begin
      rdata_next = irq_src_reg;
    end else if (acc_index_i == IDX_IRQ_MASK) begin
      rdata_next = mask_q;
    end else if (acc_index_i == IDX_SPCTRL) begin
      rdata_next = spctrl_q;
    end else begin
      rdata_next = 16'h0000;
    end
  end

  // ==========================================================
  // answer register
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      rsp_valid_reg <= 1'b0;
      rdata_reg <= 16'h0000;
      rsp_idx_reg <= 5'h00;
    end else begin
      rsp_valid_reg <= acc_valid_i;
      rsp_idx_reg <= acc_index_i;
      rdata_reg <= rd ? rdata_next : 16'h0000;
    end
  end

  // ==========================================================
  // effective speed and duplex
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      spd_out_reg <= 1'b0;
      dup_out_reg <= 1'b0;
    end else begin
      spd_out_reg <= anen_reg ? an_spd_reg : spd_reg;
      dup_out_reg <= anen_reg ? an_dup_reg : dup_reg;
    end
  end

  assign rsp_valid_o = rsp_valid_reg;
  assign rsp_rdata_o = rdata_reg;
  assign soft_reset_o = soft_pulse_reg;
  assign loopback_o = loop_reg;
  assign speed100_o = spd_out_reg;
  assign full_duplex_o = dup_out_reg;
  assign an_enable_o = anen_reg;
  assign an_restart_o = anrs_reg;
  assign power_down_o = pdn_reg;
  assign coll_test_o = colt_reg;

  // ==========================================================
  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);

  AST_SRST_SC: assert property (srst_req ##1 !srst_req [*1] |->
    ##(SRC) !ctrl_val[B_SRST])
    else $error("soft reset bit did not self-clear");
  AST_SRST_PULSE: assert property (srst_req |=> soft_reset_o ##1
    !soft_reset_o || $past(srst_req))
    else $error("soft reset pulse wrong");
  AST_KEEP: assert property (soft_reset_o |=>
    (spmode_q & KEEP_SPMODE) == ($past(spmode_q) & KEEP_SPMODE))
    else $error("kept field lost on soft reset");
  AST_LOOP: assert property (wr_ctrl && !acc_wdata_i[B_SRST]
    && !soft_reset_o |=> loopback_o == $past(acc_wdata_i[B_LOOP]))
    else $error("loopback not written");
  AST_SPD_MAN: assert property (!anen_reg |=>
    speed100_o == $past(spd_reg))
    else $error("manual speed not applied");
  AST_DUP_AN: assert property (anen_reg |=>
    full_duplex_o == $past(an_dup_reg))
    else $error("duplex not overridden by autoneg");
  AST_ANEN_RST: assert property ($past(sys_rst_i) |-> an_enable_o)
    else $error("autoneg enable not set after reset");
  AST_ANC: assert property (an_done_i && anen_reg && !pdn_reg |=>
    stat_val[S_ANC])
    else $error("autoneg completion not shown");
  AST_RESTART: assert property (wr_ctrl && !acc_wdata_i[B_SRST]
    && acc_wdata_i[B_ANRS] |=> an_restart_o ##1
    !an_restart_o || $past(wr_ctrl))
    else $error("restart bit not self-clearing");
  AST_COLT: assert property (wr_ctrl && !acc_wdata_i[B_SRST]
    && !soft_reset_o |=> coll_test_o == $past(acc_wdata_i[B_COLT]))
    else $error("collision test not written");
  AST_RSV: assert property (rsp_valid_o && rsp_idx_reg == IDX_BCTRL
    |-> rsp_rdata_o[10] == 1'b0 && rsp_rdata_o[6:0] == 7'h00)
    else $error("reserved control bits not zero");
  AST_IDHI: assert property (rd && acc_index_i == IDX_ID_HI |=>
    rsp_valid_o && rsp_rdata_o == ID_HI)
    else $error("identifier index misdecoded");
  AST_UNMAP: assert property (rd && acc_index_i == 5'h07 |=>
    rsp_valid_o && rsp_rdata_o == 16'h0000)
    else $error("unmapped index not zero");

  COV_SRST: cover property (srst_req ##1 soft_reset_o);
  COV_RESTART: cover property (an_restart_o);
  COV_ANC: cover property (an_done_i ##1 an_cmpl_reg);
  COV_UNMAP: cover property (rd && acc_index_i == 5'h0A);
endmodule : pmr_bank
`default_nettype wire

/* File: hw/pmr_field_reg.sv */
// pmr_field_reg: one 16-bit management register with write mask and
// a set of fields kept over a soft reset.
// assumes: hard and soft reset are synchronous to clk_i.
`timescale 1ns/1ps
`default_nettype none
module pmr_field_reg #(
  parameter logic [15:0] RST_VAL = 16'h0000,
  parameter logic [15:0] WR_MASK = 16'hFFFF,
  parameter logic [15:0] KEEP_MASK = 16'h0000
) (
  // clock and resets
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic soft_rst_i,
  // write port
  input wire logic wr_en_i,
  input wire logic [15:0] wdata_i,
  // value
  output logic [15:0] q_o
);
  logic [15:0] q_reg;

  // ==========================================================
  // storage
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      q_reg <= RST_VAL;
    end else if (soft_rst_i) begin
      q_reg <= (q_reg & KEEP_MASK) | (RST_VAL & ~KEEP_MASK);
    end else if (wr_en_i) begin
      q_reg <= (q_reg & ~WR_MASK) | (wdata_i & WR_MASK);
    end
  end

  assign q_o = q_reg;
endmodule : pmr_field_reg
`default_nettype wire

/* File: hw/pmr_pkg.sv */
// pmr_pkg: index map, field positions, reset values and timing of the
// PHY management register bank.
// assumes: one 100 MHz system clock shared by all users.
package pmr_pkg;
  // ==========================================================
  // register indices
  localparam logic [4:0] IDX_BCTRL = 5'h00;
  localparam logic [4:0] IDX_BSTAT = 5'h01;
  localparam logic [4:0] IDX_ID_HI = 5'h02;
  localparam logic [4:0] IDX_ID_LO = 5'h03;
  localparam logic [4:0] IDX_ADV = 5'h04;
  localparam logic [4:0] IDX_PARTNER = 5'h05;
  localparam logic [4:0] IDX_EXPAN = 5'h06;
  localparam logic [4:0] IDX_MODE = 5'h11;
  localparam logic [4:0] IDX_SPMODE = 5'h12;
  localparam logic [4:0] IDX_SPIND = 5'h1B;
  localparam logic [4:0] IDX_IRQ_SRC = 5'h1D;
  localparam logic [4:0] IDX_IRQ_MASK = 5'h1E;
  localparam logic [4:0] IDX_SPCTRL = 5'h1F;
  // ==========================================================
  // basic control bit positions
  localparam int B_SRST = 15;
  localparam int B_LOOP = 14;
  localparam int B_SPD = 13;
  localparam int B_ANEN = 12;
  localparam int B_PDN = 11;
  localparam int B_ANRS = 9;
  localparam int B_DUP = 8;
  localparam int B_COLT = 7;
  // ==========================================================
  // basic status bit positions
  localparam int S_ANC = 5;
  localparam int S_LINK = 2;
  // ==========================================================
  // reset values, write masks and kept-field masks
  localparam logic RST_LOOP = 1'b0;
  localparam logic RST_ANEN = 1'b1;
  localparam logic RST_PDN = 1'b0;
  localparam logic RST_COLT = 1'b0;
  localparam logic [15:0] BSTAT_FIXED = 16'h7809;
  localparam logic [15:0] RST_ADV = 16'h01E1;
  localparam logic [15:0] WM_ADV = 16'h2DFF;
  localparam logic [15:0] RST_ZERO = 16'h0000;
  localparam logic [15:0] WM_ALL = 16'hFFFF;
  localparam logic [15:0] KEEP_NONE = 16'h0000;
  localparam logic [15:0] KEEP_SPMODE = 16'h00FF;
  // ==========================================================
  // soft reset hold time
  localparam int CLK_NS = 10;
  localparam int SRST_NS = 160;
  localparam int SRST_CYC = (SRST_NS + CLK_NS - 1) / CLK_NS;
endpackage : pmr_pkg

/* File: tb/pmr_an_model.sv */
// pmr_an_model: behavioural autoneg engine and line at the bank's far side.
// assumes: runs on the bank's clock; result only valid beside done or reset.
`timescale 1ns/1ps
`default_nettype none
module pmr_an_model (
  // clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // control from bank
  input wire logic an_restart_i,
  input wire logic power_down_i,
  // bench settings
  input wire logic [7:0] delay_i,
  input wire logic res_speed_i,
  input wire logic res_dup_i,
  // result to bank
  output logic an_done_o,
  output logic speed100_o,
  output logic full_duplex_o,
  output logic link_up_o
);
  // ==========================================================
  // negotiation timer
  logic [7:0] cnt_reg;
  always_ff @(posedge clk_i) begin
    if (sys_rst_i || power_down_i) begin
      cnt_reg <= 8'h00;
    end else if (an_restart_i) begin
      cnt_reg <= delay_i;
    end else if (cnt_reg != 8'h00) begin
      cnt_reg <= cnt_reg - 8'h01;
    end
  end
  // completion only after restart, never while powered down
  assign an_done_o = (cnt_reg == 8'h01) && !power_down_i;
  // result lines carry junk outside done and reset
  assign speed100_o = (an_done_o || sys_rst_i) ? res_speed_i : ~res_speed_i;
  assign full_duplex_o = (an_done_o || sys_rst_i) ? res_dup_i : ~res_dup_i;
  assign link_up_o = !power_down_i;
endmodule : pmr_an_model
`default_nettype wire

/* File: tb/tb.sv */
// tb: self-checking bench of the phy management register bank.
// assumes: pmr_pkg compiled first; autoneg partner in pmr_an_model.
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) check_val(16'(got), 16'(exp))
module tb;
  import pmr_pkg::*;
  // ==========================================================
  // signals
  logic clk_i = 1'b0, sys_rst_i = 1'b1;
  logic acc_valid_i = 1'b0, acc_write_i = 1'b0;
  logic [4:0] acc_index_i = 5'h00;
  logic [15:0] acc_wdata_i = 16'h0000, partner = 16'h5A3C, rd;
  logic rsp_valid_o, an_done, an_spd, an_dup, link_up;
  logic [15:0] rsp_rdata_o;
  logic soft_reset_o, loopback_o, speed100_o, full_duplex_o;
  logic an_enable_o, an_restart_o, power_down_o, coll_test_o;
  logic [7:0] an_delay = 8'h14;
  logic res_spd = 1'b1, res_dup = 1'b1, srst_seen, rst_seen;
  int miscompares = 0, samples_checked = 0, cycles = 0;
  localparam logic [15:0] IDH = 16'hA5A5; // arbitrary value
  localparam logic [15:0] IDL = 16'h3C96; // arbitrary value
  // ==========================================================
  // design and partner
  pmr_bank #(.ID_HI(IDH), .ID_LO(IDL), .EXPAN_VAL(16'h0000)) dut (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .acc_valid_i(acc_valid_i),
    .acc_write_i(acc_write_i), .acc_index_i(acc_index_i),
    .acc_wdata_i(acc_wdata_i), .rsp_valid_o(rsp_valid_o),
    .rsp_rdata_o(rsp_rdata_o), .an_done_i(an_done),
    .an_speed100_i(an_spd), .an_full_duplex_i(an_dup),
    .link_up_i(link_up), .partner_ability_i(partner),
    .irq_event_i(16'h0000), .soft_reset_o(soft_reset_o),
    .loopback_o(loopback_o), .speed100_o(speed100_o),
    .full_duplex_o(full_duplex_o), .an_enable_o(an_enable_o),
    .an_restart_o(an_restart_o), .power_down_o(power_down_o),
    .coll_test_o(coll_test_o));
  pmr_an_model partner_m (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .an_restart_i(an_restart_o),
    .power_down_i(power_down_o), .delay_i(an_delay),
    .res_speed_i(res_spd), .res_dup_i(res_dup), .an_done_o(an_done),
    .speed100_o(an_spd), .full_duplex_o(an_dup), .link_up_o(link_up));
  // ==========================================================
  // clock, timeout
  initial begin
    forever #5 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      finish_test();
    end
  end
  // ==========================================================
  // helpers
  task automatic check_val(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check_val
  task automatic access(input logic wr, input logic [4:0] idx,
                        input logic [15:0] wd);
    @(negedge clk_i);
    acc_valid_i = 1'b1;
    acc_write_i = wr;
    acc_index_i = idx;
    acc_wdata_i = wd;
    @(negedge clk_i);
    `CHK(rsp_valid_o, 1'b1);
    rd = rsp_rdata_o;
    srst_seen = soft_reset_o;
    rst_seen = an_restart_o;
    acc_valid_i = 1'b0;
    acc_write_i = 1'b0;
    if (wr) begin
      `CHK(rd, 16'h0000);
    end
  endtask : access
  task automatic rd_chk(input logic [4:0] idx, input logic [15:0] mask,
                        input logic [15:0] exp);
    access(1'b0, idx, 16'h0000);
    `CHK(rd & mask, exp);
  endtask : rd_chk
  task automatic hard_reset();
    @(negedge clk_i);
    sys_rst_i = 1'b1;
    repeat (2) @(negedge clk_i);
    sys_rst_i = 1'b0;
  endtask : hard_reset
  task automatic wait_done();
    int n;
    for (n = 0; n < 300 && an_done !== 1'b1; n++) @(negedge clk_i);
    `CHK(an_done, 1'b1);
    repeat (2) @(negedge clk_i);
  endtask : wait_done
  function automatic logic mapped(input logic [4:0] i);
    return i <= 5'h06 || i == 5'h11 || i == 5'h12 || i == 5'h1B ||
           i >= 5'h1D;
  endfunction : mapped
  // ==========================================================
  // scenarios
  task automatic t_reset_values();
    rd_chk(IDX_BCTRL, 16'hFFFF, 16'h3100);
    `CHK({an_enable_o, loopback_o, power_down_o, coll_test_o}, 4'h8);
    `CHK({speed100_o, full_duplex_o, an_restart_o}, 3'h0);
    rd_chk(IDX_BSTAT, 16'hFFDB, BSTAT_FIXED);
    rd_chk(IDX_ID_HI, 16'hFFFF, IDH);
    rd_chk(IDX_ID_LO, 16'hFFFF, IDL);
    rd_chk(IDX_ADV, 16'hFFFF, 16'h01E1);
    rd_chk(IDX_PARTNER, 16'hFFFF, 16'h5A3C);
  endtask : t_reset_values
  task automatic t_index_map();
    int i;
    logic [4:0] idx;
    for (i = 0; i < 32; i++) begin
      if (!mapped(5'(i))) begin
        access(1'b1, 5'(i), 16'hFFFF);
        rd_chk(5'(i), 16'hFFFF, 16'h0000);
      end
    end
    rd_chk(IDX_BCTRL, 16'hFFFF, 16'h3100);
    rd_chk(IDX_ADV, 16'hFFFF, 16'h01E1);
    for (i = 0; i < 4; i++) begin
      idx = i[1] ? (i[0] ? IDX_SPCTRL : IDX_IRQ_MASK)
                 : (i[0] ? IDX_SPIND : IDX_MODE);
      access(1'b1, idx, 16'hA5C3);
      `CHK(rd, 16'h0000);
      rd_chk(IDX_SPMODE, 16'hFFFF, 16'h0000);
      rd_chk(idx, 16'hFFFF, 16'hA5C3);
    end
    access(1'b1, IDX_ID_HI, 16'h0000);
    rd_chk(IDX_ID_HI, 16'hFFFF, IDH);
  endtask : t_index_map
  task automatic t_ctrl_bits();
    access(1'b1, IDX_BCTRL, 16'h65FF);
    rd_chk(IDX_BCTRL, 16'hFFFF, 16'h6180);
    `CHK({loopback_o, speed100_o, full_duplex_o}, 3'h7);
    `CHK({an_enable_o, coll_test_o, power_down_o}, 3'h2);
    access(1'b1, IDX_BCTRL, 16'h4880);
    rd_chk(IDX_BCTRL, 16'hFFFF, 16'h4880);
    `CHK({power_down_o, speed100_o, full_duplex_o}, 3'h4);
  endtask : t_ctrl_bits
  task automatic t_autoneg();
    access(1'b1, IDX_BCTRL, 16'h3100);
    res_spd = 1'b0;
    res_dup = 1'b0;
    an_delay = 8'h28;
    access(1'b1, IDX_BCTRL, 16'h3300);
    `CHK(rst_seen, 1'b1);
    rd_chk(IDX_BCTRL, 16'hFFFF, 16'h3100);
    rd_chk(IDX_BSTAT, 16'h0020, 16'h0000);
    wait_done();
    rd_chk(IDX_BSTAT, 16'h0020, 16'h0020);
    `CHK({speed100_o, full_duplex_o}, 2'h0);
    access(1'b1, IDX_BCTRL, 16'h1800);
    `CHK(power_down_o, 1'b1);
    rd_chk(IDX_BSTAT, 16'h0020, 16'h0000);
    an_delay = 8'h05;
    access(1'b1, IDX_BCTRL, 16'h1000);
    `CHK(rst_seen, 1'b1);
    wait_done();
    rd_chk(IDX_BSTAT, 16'h0020, 16'h0020);
  endtask : t_autoneg
  task automatic t_soft_reset();
    access(1'b1, IDX_BCTRL, 16'h4000);
    access(1'b1, IDX_SPMODE, 16'h00A5);
    access(1'b1, IDX_MODE, 16'h1234);
    access(1'b1, IDX_ADV, 16'h0000);
    access(1'b1, IDX_BCTRL, 16'h8000);
    `CHK(srst_seen, 1'b1);
    rd_chk(IDX_BCTRL, 16'h8000, 16'h8000);
    repeat (16) @(negedge clk_i);
    rd_chk(IDX_BCTRL, 16'hFFFF, 16'h1000);
    `CHK(loopback_o, 1'b0);
    rd_chk(IDX_ADV, 16'hFFFF, 16'h01E1);
    rd_chk(IDX_MODE, 16'hFFFF, 16'h0000);
    rd_chk(IDX_SPMODE, 16'h00FF, 16'h00A5);
    hard_reset();
    rd_chk(IDX_SPMODE, 16'h00FF, 16'h0000);
    rd_chk(IDX_BCTRL, 16'hFFFF, 16'h1000);
  endtask : t_soft_reset
  task automatic finish_test();
    $display("miscompares %0d samples_checked %0d", miscompares,
             samples_checked);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : finish_test
  // ==========================================================
  // main sequence
  initial begin
    repeat (2) @(negedge clk_i);
    sys_rst_i = 1'b0;
    t_reset_values();
    t_index_map();
    t_ctrl_bits();
    t_autoneg();
    t_soft_reset();
    finish_test();
  end
endmodule : tb
`default_nettype wire
